// ### common/eeprom_host_pkg.sv
package eeprom_host_pkg;

  // bus timing, 100 kHz serial clock from a 100 MHz core clock
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SCL_PERIOD_NS    = 10000;
  localparam int QTR_CYC          = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int BUS_IDLE_GAP_NS  = 4700;
  localparam int BUS_IDLE_GAP_CYC =
    (BUS_IDLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // power-up and self-timed write figures, in milliseconds and in core clock cycles
  localparam int POWER_UP_READ_DELAY_MS  = 1;
  localparam int POWER_UP_WRITE_DELAY_MS = 5;
  localparam int INTERNAL_WRITE_TYP_MS   = 5;
  localparam int INTERNAL_WRITE_TIME_MS  = 10;
  localparam int NS_PER_MS               = 1000000;
  localparam int POWER_UP_READ_CYC  =
    POWER_UP_READ_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int POWER_UP_WRITE_CYC =
    POWER_UP_WRITE_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int INTERNAL_WRITE_CYC =
    INTERNAL_WRITE_TIME_MS * (NS_PER_MS / CLK_PERIOD_NS);

  // widths
  localparam int CNT_W     = 20;
  localparam int QCNT_W    = 10;
  localparam int ADDR_W    = 10;
  localparam int BYTE_W    = 8;
  localparam int TYPE_W    = 4;
  localparam int PHASE_W   = 3;
  localparam int BITIDX_W  = 4;

  // phase positions inside start, bit and stop sequences (quarter periods), and the bit index of the acknowledge clock
  localparam logic [PHASE_W-1:0]  PH_HOLD      = 3'h0;
  localparam logic [PHASE_W-1:0]  PH_SCL_HIGH  = 3'h2;
  localparam logic [PHASE_W-1:0]  PH_SAMPLE    = 3'h3;
  localparam logic [PHASE_W-1:0]  PH_STA_LOW   = 3'h4;
  localparam logic [PHASE_W-1:0]  PH_STA_LAST  = 3'h5;
  localparam logic [PHASE_W-1:0]  PH_STO_REL   = 3'h4;
  localparam logic [BITIDX_W-1:0] BIT_ACK      = 4'h8;

  // direction bit of the slave address byte
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ  = 1'b1;

  typedef enum logic [1:0] {
    OP_CUR_READ,
    OP_RAND_READ,
    OP_POLL
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_GAP,
    ST_START,
    ST_BITS,
    ST_STOP
  } state_t;

  typedef enum logic [1:0] {
    STEP_ADDR_W,
    STEP_WORD,
    STEP_ADDR_R,
    STEP_DATA
  } step_t;

endpackage : eeprom_host_pkg

// ### core/eeprom_host.sv
`timescale 1ns/100ps
module eeprom_host #(
  parameter int          PWRUP_RD_CYC = eeprom_host_pkg::POWER_UP_READ_CYC,
  parameter int          PWRUP_WR_CYC = eeprom_host_pkg::POWER_UP_WRITE_CYC,
  parameter int          POLL_LIM_CYC = eeprom_host_pkg::INTERNAL_WRITE_CYC,
  // arbitrary device type code
  parameter logic [3:0]  TYPE_CODE    = 4'h6
) (
  input  wire logic                           CLK,
  input  wire logic                           ARST_N,
  input  wire logic                           CMD_VALID,
  input  wire eeprom_host_pkg::op_t           CMD_OP,
  input  wire logic [eeprom_host_pkg::ADDR_W-1:0] CMD_ADDR,
  input  wire logic [eeprom_host_pkg::ADDR_W-1:0] CMD_COUNT,
  input  wire logic                           CHIP_SEL,
  output logic                                CMD_READY,
  output logic                                BUSY,
  output logic                                RD_VALID,
  output logic [eeprom_host_pkg::BYTE_W-1:0]  RD_DATA,
  output logic                                DONE,
  output logic                                FAIL,
  output logic                                SCL,
  input  wire logic                           SDA_IN,
  output logic                                SDA_OUT,
  output logic                                SDA_OE_N
);
  import eeprom_host_pkg::*;

  function automatic logic [BYTE_W-1:0] slave_byte(
    input logic [TYPE_W-1:0] code,
    input logic              cs,
    input logic [1:0]        hi,
    input logic              dir
  );
    slave_byte = {code, cs, hi, dir};
  endfunction : slave_byte

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  state_t                state_r,  state_nxt;
  step_t                 step_r,   step_nxt;
  op_t                   op_r,     op_nxt;
  logic [ADDR_W-1:0]     addr_r,   addr_nxt;
  logic [ADDR_W-1:0]     count_r,  count_nxt;
  logic                  cs_r,     cs_nxt;
  logic [PHASE_W-1:0]    phase_r,  phase_nxt;
  logic [BITIDX_W-1:0]   bit_r,    bit_nxt;
  logic [QCNT_W-1:0]     qcnt_r,   qcnt_nxt;
  logic [BYTE_W-1:0]     shift_r,  shift_nxt;
  logic                  again_r,  again_nxt;
  logic                  fpend_r,  fpend_nxt;
  logic [CNT_W-1:0]      pwr_r;
  logic [CNT_W-1:0]      poll_r;
  logic                  sda_s1_r, sda_s2_r;
  logic                  scl_r,    oe_n_r;
  logic                  rdv_r,    rdv_nxt;
  logic [BYTE_W-1:0]     rdd_r,    rdd_nxt;
  logic                  done_r,   done_nxt;
  logic                  fail_r,   fail_nxt;
  logic                  ready_r,  busy_r;

  // decode
  wire        tick      = (qcnt_r == QCNT_W'(QTR_CYC - 1));
  wire        gap_done  = (qcnt_r >= QCNT_W'(BUS_IDLE_GAP_CYC - 1));
  wire        cmd_take  = CMD_VALID && ready_r && (state_r == ST_IDLE);
  wire        sda_low   = ~sda_s2_r;
  wire        rd_ok     = (pwr_r >= CNT_W'(PWRUP_RD_CYC));
  wire        wr_ok     = (pwr_r >= CNT_W'(PWRUP_WR_CYC));
  wire        pwr_ok    = (op_r == OP_CUR_READ) ? rd_ok
                          : (wr_ok && rd_ok);
  wire        poll_over = (poll_r >= CNT_W'(POLL_LIM_CYC));
  wire        is_rx     = (step_r == STEP_DATA);
  wire        last_byte = (count_r == '0);
  wire        byte_end  = (state_r == ST_BITS) && tick
                          && (phase_r == PH_SAMPLE) && (bit_r == BIT_ACK);
  wire        scl_high  = (phase_r >= PH_SCL_HIGH);
  wire        hold_pull = ~SDA_OE_N;
  wire [BYTE_W-1:0] wr_byte = slave_byte(TYPE_CODE, cs_r,
                                         addr_r[ADDR_W-1:BYTE_W], DIR_WRITE);
  wire [BYTE_W-1:0] rd_byte = slave_byte(TYPE_CODE, cs_r,
                                         addr_r[ADDR_W-1:BYTE_W], DIR_READ);
  wire [BYTE_W-1:0] load_byte =
    (step_r == STEP_ADDR_W) ? wr_byte :
    (step_r == STEP_WORD)   ? addr_r[BYTE_W-1:0] :
    (step_r == STEP_ADDR_R) ? rd_byte : '0;

  // data bit pulled low: tx follows the shifter, rx acknowledges only while
  // more bytes are wanted, so the last ninth clock sees SDA released
  wire        tx_pull  = (bit_r == BIT_ACK) ? 1'b0 : ~shift_r[BYTE_W-1];
  wire        rx_pull  = (bit_r == BIT_ACK) && !last_byte;
  wire        bit_pull = is_rx ? rx_pull : tx_pull;

  // pin levels wanted for the current state and phase
  wire scl_want =
    (state_r == ST_START) ? scl_high :
    (state_r == ST_BITS)  ? scl_high :
    (state_r == ST_STOP)  ? scl_high : 1'b1;
  wire pull_want =
    (state_r == ST_START) ? ((phase_r == PH_HOLD) ? hold_pull
                             : (phase_r >= PH_STA_LOW)) :
    (state_r == ST_BITS)  ? ((phase_r == PH_HOLD) ? hold_pull : bit_pull) :
    (state_r == ST_STOP)  ? ((phase_r == PH_HOLD) ? hold_pull
                             : (phase_r < PH_STO_REL)) : 1'b0;

  always_comb begin
    state_nxt = state_r;
    step_nxt  = step_r;
    op_nxt    = op_r;
    addr_nxt  = addr_r;
    count_nxt = count_r;
    cs_nxt    = cs_r;
    phase_nxt = phase_r;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    again_nxt = again_r;
    fpend_nxt = fpend_r;
    rdv_nxt   = 1'b0;
    rdd_nxt   = rdd_r;
    done_nxt  = 1'b0;
    fail_nxt  = fail_r;
    qcnt_nxt  = tick ? '0 : qcnt_r + 1'b1;
    case (state_r)
      ST_IDLE: begin
        qcnt_nxt = '0;
        if (cmd_take) begin
          op_nxt    = CMD_OP;
          addr_nxt  = CMD_ADDR;
          count_nxt = CMD_COUNT;
          cs_nxt    = CHIP_SEL;
          step_nxt  = (CMD_OP == OP_CUR_READ) ? STEP_ADDR_R
                      : STEP_ADDR_W;
          again_nxt = 1'b1;
          fpend_nxt = 1'b0;
          state_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        qcnt_nxt = gap_done ? qcnt_r : qcnt_r + 1'b1;
        if (gap_done && !again_r) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
          fail_nxt  = fpend_r;
        end else if (gap_done && pwr_ok) begin
          state_nxt = ST_START;
          phase_nxt = '0;
          qcnt_nxt  = '0;
        end
      end
      ST_START: begin
        if (tick) begin
          phase_nxt = phase_r + 1'b1;
          if (phase_r == PH_STA_LAST) begin
            state_nxt = ST_BITS;
            phase_nxt = '0;
            bit_nxt   = '0;
            shift_nxt = load_byte;
          end
        end
      end
      ST_BITS: begin
        if (tick) begin
          phase_nxt = phase_r + 1'b1;
          if (phase_r == PH_SAMPLE) begin
            phase_nxt = '0;
            bit_nxt   = bit_r + 1'b1;
            if (bit_r != BIT_ACK) begin
              shift_nxt = is_rx ? {shift_r[BYTE_W-2:0], sda_s2_r}
                                : {shift_r[BYTE_W-2:0], 1'b0};
            end
          end
        end
        if (byte_end) begin
          bit_nxt = '0;
          case (step_r)
            STEP_ADDR_W: begin
              if (sda_low && (op_r == OP_POLL)) begin
                state_nxt = ST_STOP;
                again_nxt = 1'b0;
              end else if (sda_low) begin
                step_nxt  = STEP_WORD;
                shift_nxt = addr_r[BYTE_W-1:0];
              end else if ((op_r == OP_POLL) && !poll_over) begin
                // device still busy writing: stop and address it again
                state_nxt = ST_STOP;
                again_nxt = 1'b1;
              end else begin
                state_nxt = ST_STOP;
                again_nxt = 1'b0;
                fpend_nxt = 1'b1;
              end
            end
            STEP_WORD: begin
              state_nxt = sda_low ? ST_START : ST_STOP;
              phase_nxt = '0;
              step_nxt  = STEP_ADDR_R;
              again_nxt = 1'b0;
              fpend_nxt = !sda_low;
            end
            STEP_ADDR_R: begin
              if (sda_low) begin
                step_nxt  = STEP_DATA;
                shift_nxt = '0;
              end else begin
                state_nxt = ST_STOP;
                again_nxt = 1'b0;
                fpend_nxt = 1'b1;
              end
            end
            default: begin
              rdv_nxt = 1'b1;
              rdd_nxt = shift_r;
              if (last_byte) begin
                state_nxt = ST_STOP;
                again_nxt = 1'b0;
              end else begin
                count_nxt = count_r - 1'b1;
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          phase_nxt = phase_r + 1'b1;
          if (phase_r == PH_STO_REL) begin
            state_nxt = ST_GAP;
            phase_nxt = '0;
            qcnt_nxt  = '0;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // two-flop synchroniser on the returned data line
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= SDA_IN;
      sda_s2_r <= sda_s1_r;
    end
  end

  // time since reset stands in for time since supply became stable
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pwr_r  <= '0;
      poll_r <= '0;
    end else begin
      pwr_r  <= sat_inc(pwr_r);
      poll_r <= cmd_take ? '0 : sat_inc(poll_r);
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= ST_IDLE;
      step_r  <= STEP_ADDR_W;
      op_r    <= OP_CUR_READ;
      addr_r  <= '0;
      count_r <= '0;
      cs_r    <= 1'b0;
      phase_r <= '0;
      bit_r   <= '0;
      qcnt_r  <= '0;
      shift_r <= '0;
      again_r <= 1'b0;
      fpend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r  <= step_nxt;
      op_r    <= op_nxt;
      addr_r  <= addr_nxt;
      count_r <= count_nxt;
      cs_r    <= cs_nxt;
      phase_r <= phase_nxt;
      bit_r   <= bit_nxt;
      qcnt_r  <= qcnt_nxt;
      shift_r <= shift_nxt;
      again_r <= again_nxt;
      fpend_r <= fpend_nxt;
    end
  end

  // outputs lag the phase decode by one cycle, far below a quarter period
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_r   <= 1'b1;
      oe_n_r  <= 1'b1;
      rdv_r   <= 1'b0;
      rdd_r   <= '0;
      done_r  <= 1'b0;
      fail_r  <= 1'b0;
      ready_r <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      scl_r   <= scl_want;
      oe_n_r  <= ~pull_want;
      rdv_r   <= rdv_nxt;
      rdd_r   <= rdd_nxt;
      done_r  <= done_nxt;
      fail_r  <= fail_nxt;
      ready_r <= (state_nxt == ST_IDLE);
      busy_r  <= (state_nxt != ST_IDLE);
    end
  end

  assign SCL       = scl_r;
  assign SDA_OUT   = 1'b0;
  assign SDA_OE_N  = oe_n_r;
  assign RD_VALID  = rdv_r;
  assign RD_DATA   = rdd_r;
  assign DONE      = done_r;
  assign FAIL      = fail_r;
  assign CMD_READY = ready_r;
  assign BUSY      = busy_r;

endmodule : eeprom_host

// ### dv/eeprom_dev_model.sv
`timescale 1ns/100ps
module eeprom_dev_model #(
  parameter logic [3:0] TYPE_CODE = 4'h6
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic cs_pin,
  output logic      sda_low
);
  localparam int S_OFF = 0;
  localparam int S_SLV = 1;
  localparam int S_WORD = 2;
  localparam int S_RD = 3;
  localparam int S_IGN = 4;
  logic [7:0] mem [1024];
  logic [9:0] addr_r = 10'h000;
  logic [7:0] sh = 8'h00;
  int st = 0;
  int bits = 0;
  int busy_polls = 0;
  initial sda_low = 1'b0;
  // wire is glitch free here, so edges are taken as is
  always @(negedge sda) if (scl) begin
    st = S_SLV;
    bits = 0;
  end
  always @(posedge sda) if (scl) st = S_OFF;
  always @(posedge scl) begin
    if (st == S_RD) begin
      if (bits == 7) addr_r = addr_r + 10'h001;
      if (bits == 8 && sda) st = S_IGN;
    end else if (st != S_OFF && st != S_IGN && bits < 8) sh = {sh[6:0], sda};
    if (st != S_OFF) bits = (bits == 8) ? 0 : bits + 1;
  end
  // each poll seen while busy uses up one unit of the write cycle
  always @(negedge scl) begin
    sda_low = 1'b0;
    if (st == S_SLV && bits == 8) begin
      if (sh[7:4] == TYPE_CODE && sh[3] == cs_pin &&
          busy_polls == 0) begin
        sda_low = 1'b1;
        st = sh[0] ? S_RD : S_WORD;
        if (!sh[0]) addr_r[9:8] = sh[2:1];
      end else begin
        if (busy_polls > 0) busy_polls--;
        st = S_IGN;
      end
    end else if (st == S_WORD && bits == 8) begin
      addr_r = {addr_r[9:8], sh};
      sda_low = 1'b1;
    end else if (st == S_RD && bits < 8) begin
      sda_low = !mem[addr_r][7 - bits];
    end
  end
endmodule : eeprom_dev_model

// ### dv/eeprom_host_checker.sv
`timescale 1ns/100ps
module eeprom_host_checker #(
  parameter int PWRUP_RD_CYC = 50,
  parameter int PWRUP_WR_CYC = 100
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CMD_VALID,
  input wire eeprom_host_pkg::op_t CMD_OP,
  input wire logic CMD_READY,
  input wire logic BUSY,
  input wire logic RD_VALID,
  input wire logic DONE,
  input wire logic SCL,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N
);
  import eeprom_host_pkg::*;
  localparam int LOW_MIN_CYC = 470;
  logic [CNT_W-1:0] up_cnt_r;
  logic [CNT_W-1:0] gap_cnt_r;
  logic [CNT_W-1:0] low_cnt_r;
  logic             scl_d_r;
  logic             oe_d_r;
  logic             wr_op_r;
  wire start_w = scl_d_r && SCL && oe_d_r && !SDA_OE_N;
  wire stop_w  = scl_d_r && SCL && !oe_d_r && SDA_OE_N;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // up and gap counters saturate so a long idle spell cannot wrap into a false fire
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      up_cnt_r  <= '0;
      gap_cnt_r <= '0;
      low_cnt_r <= '0;
      scl_d_r   <= 1'b1;
      oe_d_r    <= 1'b1;
      wr_op_r   <= 1'b0;
    end else begin
      // ops that open with a write-direction address need the longer delay
      wr_op_r   <= (CMD_VALID && CMD_READY) ? (CMD_OP != OP_CUR_READ)
                                            : wr_op_r;
      up_cnt_r  <= (&up_cnt_r) ? up_cnt_r : up_cnt_r + 1'b1;
      gap_cnt_r <= stop_w ? '0 : (&gap_cnt_r) ? gap_cnt_r : gap_cnt_r + 1'b1;
      low_cnt_r <= SCL ? '0 : low_cnt_r + 1'b1;
      scl_d_r   <= SCL;
      oe_d_r    <= SDA_OE_N;
    end
  end
  take_drops_ready_a: assert property (CMD_VALID && CMD_READY |=>
    !CMD_READY && BUSY) else $error("take did not start the command");
  done_pulse_a: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  done_ready_a: assert property (DONE |-> CMD_READY && !BUSY)
    else $error("done without ready");
  busy_end_a: assert property ($fell(BUSY) |-> DONE)
    else $error("busy ended without done");
  rd_pulse_a: assert property (RD_VALID |=> !RD_VALID)
    else $error("read strobe longer than one cycle");
  rd_busy_a: assert property (RD_VALID |-> BUSY)
    else $error("read strobe outside a command");
  bus_gap_a: assert property (
    start_w |-> gap_cnt_r >= BUS_IDLE_GAP_CYC)
    else $error("start too soon after stop");
  power_up_a: assert property (
    start_w |-> up_cnt_r >= PWRUP_RD_CYC)
    else $error("start before power-up delay");
  power_wr_a: assert property (
    start_w && wr_op_r |-> up_cnt_r >= PWRUP_WR_CYC)
    else $error("write start before power-up write delay");
  scl_low_a: assert property ($rose(SCL) |-> low_cnt_r >= LOW_MIN_CYC)
    else $error("serial clock low too short");
  open_drain_a: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  done_c: cover property (DONE);
  rd_c: cover property (RD_VALID);
  start_c: cover property (start_w);
endmodule : eeprom_host_checker
bind eeprom_host eeprom_host_checker #(.PWRUP_RD_CYC(PWRUP_RD_CYC),
  .PWRUP_WR_CYC(PWRUP_WR_CYC)) i_chk (
  .CLK(CLK), .ARST_N(ARST_N), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
  .CMD_READY(CMD_READY),
  .BUSY(BUSY), .RD_VALID(RD_VALID), .DONE(DONE), .SCL(SCL),
  .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N));

// ### dv/test_eeprom_host.sv
`timescale 1ns/100ps
module test_eeprom_host;
  import eeprom_host_pkg::*;
  localparam logic [3:0] TYPE_CODE = 4'h6; // arbitrary device type code
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  logic              cmd_valid = 1'b0;
  op_t               cmd_op = OP_POLL;
  logic [ADDR_W-1:0] cmd_addr = '0;
  logic [ADDR_W-1:0] cmd_count = '0;
  logic              chip_sel = 1'b0;
  logic              dev_cs = 1'b0;
  logic              cmd_ready, busy, rd_valid, done, fail;
  logic              scl, sda_out, sda_oe_n, dev_low;
  logic [BYTE_W-1:0] rd_data;
  wire               sda = (sda_oe_n === 1'b0 || dev_low === 1'b1) ?
                           1'b0 : 1'b1;
  logic [BYTE_W-1:0] exp_mem [1024];
  logic [BYTE_W-1:0] got_q [$];
  logic [31:0]       seed = 32'h05C7;
  int                err_total = 0;
  int                check_count = 0;
  int                cyc = 0;
  always #5 clk = ~clk;
  eeprom_host #(.PWRUP_RD_CYC(2000), .PWRUP_WR_CYC(3000), .POLL_LIM_CYC(40000),
    .TYPE_CODE(TYPE_CODE)) i_dut (
    .CLK(clk), .ARST_N(arst_n), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_COUNT(cmd_count), .CHIP_SEL(chip_sel),
    .CMD_READY(cmd_ready), .BUSY(busy), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .DONE(done), .FAIL(fail), .SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n));
  eeprom_dev_model #(.TYPE_CODE(TYPE_CODE)) p_dev (
    .scl(scl), .sda(sda), .cs_pin(dev_cs), .sda_low(dev_low));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // drives one command and gathers every byte until the done strobe
  task automatic run_cmd(input op_t op, input logic [ADDR_W-1:0] addr,
                         input logic [ADDR_W-1:0] cnt);
    int n;
    n = 0;
    got_q.delete();
    chk("ready", 1, cmd_ready);
    cmd_op = op;
    cmd_addr = addr;
    cmd_count = cnt;
    cmd_valid = 1'b1;
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 80000) begin
      @(posedge clk) #1;
      n++;
      if (rd_valid === 1'b1) got_q.push_back(rd_data);
    end
    chk("done", 1, done);
  endtask : run_cmd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 150000) begin
      err_total++;
      $display("[ERR] run length expected done seen hang");
      finish_test();
    end
  end
  initial begin
    for (int i = 0; i < 1024; i++) begin
      seed = xs(seed);
      exp_mem[i] = seed[7:0];
      p_dev.mem[i] = seed[7:0];
    end
    chip_sel = seed[8];
    dev_cs = seed[8];
    repeat (5) @(posedge clk);
    #1 arst_n = 1'b1;
    @(posedge clk) #1;
    p_dev.busy_polls = 1;
    run_cmd(OP_POLL, 10'h000, 10'h000);
    chk("poll_fail", 0, fail);
    chk("poll_nacks", 0, p_dev.busy_polls);
    run_cmd(OP_RAND_READ, 10'h3FF, 10'h001);
    chk("rand_fail", 0, fail);
    chk("rand_len", 2, got_q.size());
    chk("rand_b0", exp_mem[1023], got_q[0]);
    chk("rand_b1", exp_mem[0], got_q[1]);
    run_cmd(OP_CUR_READ, 10'h000, 10'h000);
    chk("cur_len", 1, got_q.size());
    chk("cur_b0", exp_mem[1], got_q[0]);
    chip_sel = ~dev_cs;
    run_cmd(OP_CUR_READ, 10'h000, 10'h000);
    chk("nack_fail", 1, fail);
    chk("nack_len", 0, got_q.size());
    finish_test();
  end
endmodule : test_eeprom_host
